// ### asp_pkg.sv
// Package for the audio status and power control register bank.
// Assumes an 8-bit register port with one-cycle strobes and registered read data.
package asp_pkg;
    localparam logic [7:0] ADDR_RATE_CALC_TARGET = 8'h37;
    localparam logic [7:0] ADDR_RATE_CALC_RESULT = 8'h38;
    localparam logic [7:0] ADDR_INCOMING_INFO = 8'h39;
    localparam logic [7:0] ADDR_BURST_INFO_LO = 8'h3A;
    localparam logic [7:0] ADDR_BURST_INFO_HI = 8'h3B;
    localparam logic [7:0] ADDR_BURST_LEN_LO = 8'h3C;
    localparam logic [7:0] ADDR_BURST_LEN_HI = 8'h3D;
    localparam logic [7:0] ADDR_SYSTEM_RESET_POWER = 8'h40;
    localparam logic [7:0] ADDR_ADC_CONTROL_ONE = 8'h42;
    localparam logic [7:0] ADDR_CRYSTAL_DIV = 8'h31;
    localparam logic [7:0] ADDR_OSC_AUTO = 8'h30;

    localparam logic [7:0] RST_RATE_CALC_TARGET = 8'h00;
    localparam logic [7:0] RST_SYSTEM_RESET_POWER = 8'hC0;
    localparam logic [7:0] RST_ADC_CONTROL_ONE = 8'h02;
    localparam logic [7:0] RST_CRYSTAL_DIV = 8'h1A;
    localparam logic [7:0] RST_OSC_AUTO = 8'h00;

    // System register bit positions.
    localparam int SYS_MODE_RESET_BIT = 7;
    localparam int SYS_ADC_RESET_BIT = 6;
    localparam int SYS_ADC_PD_BIT = 5;
    localparam int SYS_RX_PD_BIT = 4;
    localparam int SYS_TX_PD_BIT = 1;
    localparam int SYS_OSC_PD_BIT = 0;

    // ADC control one, crystal divider and oscillator auto bit positions.
    localparam int ADC_CLKOUT_GATE_BIT = 5;
    localparam int ADC_DATA_SRC_BIT = 4;
    localparam int ADC_RATE_LIMIT_BIT = 3;
    localparam int ADC_CLK_SRC_LSB = 0;
    localparam int CRYSTAL_SYSCLK_DIV_LSB = 4;
    localparam int OSC_AUTO_BIT = 0;

    // Result and incoming info register field positions.
    localparam int RES_BUSY_BIT = 7;
    localparam int RES_PORT_LSB = 4;
    localparam int INFO_NONAUDIO_BIT = 6;

    // Rate code for out of range, and the limiter window 14 to 111 kHz.
    localparam logic [3:0] RATE_OUT_OF_RANGE = 4'h0;
    localparam logic [3:0] RATE_CODE_16K = 4'h4;
    localparam logic [3:0] RATE_CODE_96K = 4'hC;

    typedef enum logic [2:0] {
        ASP_PORT_RECEIVER = 3'h0,
        ASP_PORT_ADC = 3'h1,
        ASP_PORT_AUX0 = 3'h2,
        ASP_PORT_AUX1 = 3'h3,
        ASP_PORT_AUX2 = 3'h4,
        ASP_PORT_MAIN_OUT = 3'h5,
        ASP_PORT_AUX_OUT = 3'h6,
        ASP_PORT_TRANSMITTER = 3'h7
    } asp_port_e;

    typedef enum logic [2:0] {
        ASP_CLK_AUTO = 3'h0,
        ASP_CLK_RECEIVER = 3'h1,
        ASP_CLK_CRYSTAL = 3'h2,
        ASP_CLK_AUX0 = 3'h3,
        ASP_CLK_AUX1 = 3'h4,
        ASP_CLK_AUX2 = 3'h5
    } asp_clk_src_e;
endpackage

// ### asp_regs.sv
// Register bank for rate status, burst preambles, resets and power control.
// Assumes measurement results arrive from logic on i_clk; pins pass two flops.
// Function
// - Three-bit target select chooses measured port, receiver at reset.
// - Result bit 7 shows one while measuring, zero when done.
// - Result bits 6 to 4 give the port actually measured.
// - Four-bit rate code, zero out of range, fifteen rates from 8 kHz.
// - No signal at port keeps busy set and the old rate code.
// - Reading status registers has no side effect.
// - Rate status only works while the receiver is powered.
// - Incoming busy set while measuring or unlocked, old rate held.
// - Channel status bit 1 mirrors into info bit 6.
// - Incoming rate in bits 3 to 0, same encoding.
// - Burst info word, low byte at first address, high at second.
// - Length word updates only together with the info word.
// - Each burst info update is signalled through update flags.
// - Writing zero to bit 7 or 6 resets; the bits restore to one.
// - Power-down bits 5, 4, 1, 0 act when one, reset zero.
// - Oscillator power-down bit overrides automatic oscillator control.
// - Clock-output bit decides if ADC clocks run during power-down.
// - Data source bit picks internal ADC or external input pin.
// - Rate limiter forces ADC power-down at receiver rates 14 to 111 kHz when the ADC clock source is the receiver.
// - Clock source codes auto, receiver, crystal, aux zero, one, two.
// - Crystal system clock divide by 1, 2, 4, 8, default by 2.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module asp_regs (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_calc_done,
    input wire logic [2:0] i_calc_port,
    input wire logic [3:0] i_calc_rate,
    input wire logic i_calc_signal,
    input wire logic i_rx_locked,
    input wire logic i_in_rate_valid,
    input wire logic [3:0] i_in_rate,
    input wire logic i_cs_bit1,
    input wire logic i_burst_valid,
    input wire logic [15:0] i_burst_info,
    input wire logic [15:0] i_burst_length,
    input wire logic i_adc_data,
    input wire logic i_ext_adc_pin,
    input wire logic i_osc_auto_req,
    output logic [2:0] o_calc_target_sel,
    output logic o_calc_enable,
    output logic o_burst_update_flag0,
    output logic o_burst_update_flag1,
    output logic o_mode_regs_reset,
    output logic o_adc_soft_reset,
    output logic o_adc_powerdown,
    output logic o_receiver_powerdown,
    output logic o_transmitter_powerdown,
    output logic o_oscillator_enable,
    output logic o_adc_clkout_enable,
    output logic o_main_data,
    output logic [2:0] o_adc_clock_source,
    output logic [1:0] o_crystal_sysclk_div
);
    logic [7:0] target_reg;
    logic [7:0] sys_reg;
    logic [7:0] adc_reg;
    logic [7:0] xdiv_reg;
    logic [7:0] osc_reg;
    logic calc_busy_flag;
    logic [2:0] calc_port_id;
    logic [3:0] calc_rate_code;
    logic incoming_rate_busy;
    logic nonaudio_cs_flag;
    logic [3:0] incoming_rate_code;
    logic [15:0] burst_info;
    logic [15:0] burst_length;
    logic ext_sync1;
    logic ext_sync2;
    logic rx_on;
    logic limiter_force;
    logic adc_pd_eff;
    logic [7:0] next_rdata;
    // Register images and fields assembled once and read by the read mux, the limiter and the outputs.
    logic [7:0] calc_result_word;
    logic [7:0] incoming_info_word;
    logic [2:0] clk_src_field;
    logic [1:0] xdiv_field;

    // Decode a write to one register address.
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] want,
                                    input logic w);
        wr_hit = w && (a == want);
    endfunction

    // Elaboration checks. Each field but the oscillator auto bit must lie inside its byte and the limiter
    // window must not be empty. A package edit that broke either would quietly
    // corrupt the decode below, so it is refused here instead.
    if (asp_pkg::SYS_MODE_RESET_BIT > 7
        || asp_pkg::SYS_ADC_RESET_BIT > 7) begin : g_chk_sys_rst
        $error("System reset bit lies outside its byte.");
    end
    if (asp_pkg::SYS_ADC_PD_BIT > 7 || asp_pkg::SYS_RX_PD_BIT > 7
        || asp_pkg::SYS_TX_PD_BIT > 7 || asp_pkg::SYS_OSC_PD_BIT > 7) begin : g_chk_sys_pd
        $error("Power-down bit lies outside its byte.");
    end
    if (asp_pkg::ADC_CLKOUT_GATE_BIT > 7 || asp_pkg::ADC_DATA_SRC_BIT > 7
        || asp_pkg::ADC_RATE_LIMIT_BIT > 7) begin : g_chk_adc_bits
        $error("Control bit lies outside its byte.");
    end
    if (asp_pkg::ADC_CLK_SRC_LSB > 5
        || asp_pkg::CRYSTAL_SYSCLK_DIV_LSB > 6) begin : g_chk_fields
        $error("Multi-bit field runs past the top of its byte.");
    end
    if (asp_pkg::RES_BUSY_BIT > 7 || asp_pkg::RES_PORT_LSB != 4
        || asp_pkg::INFO_NONAUDIO_BIT > 7) begin : g_chk_status
        $error("Status field overlaps the rate code or leaves its byte.");
    end
    if (asp_pkg::RATE_CODE_16K > asp_pkg::RATE_CODE_96K) begin : g_chk_window
        $error("Limiter window is empty.");
    end
    if (asp_pkg::RATE_OUT_OF_RANGE >= asp_pkg::RATE_CODE_16K) begin : g_chk_range
        $error("Out-of-range code falls inside the limiter window.");
    end

    // Receiver power gates every status path below.
    assign rx_on = !sys_reg[asp_pkg::SYS_RX_PD_BIT];

    // Clock source and divider fields, sliced once for the limiter and the outputs.
    assign clk_src_field = adc_reg[asp_pkg::ADC_CLK_SRC_LSB +: 3];
    assign xdiv_field = xdiv_reg[asp_pkg::CRYSTAL_SYSCLK_DIV_LSB +: 2];

    // The 14 to 111 kHz window holds the codes from 16 kHz up to 96 kHz, since
    // 12 kHz lies below it and 128 kHz above it. A busy or unlocked receiver
    // never forces power-down, so a stale rate cannot hold the ADC off.
    // limiter window
    assign limiter_force = adc_reg[asp_pkg::ADC_RATE_LIMIT_BIT]
        && (clk_src_field == asp_pkg::ASP_CLK_RECEIVER) && i_rx_locked
        && !incoming_rate_busy
        && (incoming_rate_code >= asp_pkg::RATE_CODE_16K)
        && (incoming_rate_code <= asp_pkg::RATE_CODE_96K);
    assign adc_pd_eff = sys_reg[asp_pkg::SYS_ADC_PD_BIT] || limiter_force;

    // Target select register; reserved bits kept as written.
    // A mode reset wins over a write in the same cycle, so defaults always land.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            target_reg <= asp_pkg::RST_RATE_CALC_TARGET;
        end else if (!sys_reg[asp_pkg::SYS_MODE_RESET_BIT]) begin
            target_reg <= asp_pkg::RST_RATE_CALC_TARGET;
        end else if (wr_hit(i_addr, asp_pkg::ADDR_RATE_CALC_TARGET, i_wr)) begin
            target_reg <= i_wdata;
        end
    end

    // System register; reset bits restore themselves one cycle after the pulse.
    // A write that clears bit 7 lands its own low bits for one cycle; the restore
    // cycle then returns them to their defaults along with the mode registers.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sys_reg <= asp_pkg::RST_SYSTEM_RESET_POWER;
        end else if (wr_hit(i_addr, asp_pkg::ADDR_SYSTEM_RESET_POWER, i_wr)) begin
            sys_reg <= i_wdata;
        end else begin
            sys_reg[asp_pkg::SYS_MODE_RESET_BIT] <= 1'b1;
            sys_reg[asp_pkg::SYS_ADC_RESET_BIT] <= 1'b1;
            if (!sys_reg[asp_pkg::SYS_MODE_RESET_BIT]) begin
                sys_reg[5:0] <= asp_pkg::RST_SYSTEM_RESET_POWER[5:0];
            end
        end
    end

    // Mode registers return to defaults while the mode reset pulse is active.
    // The oscillator auto bit and the crystal divider live here as well, so a
    // mode reset returns the clock tree to its quiet default.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            adc_reg <= asp_pkg::RST_ADC_CONTROL_ONE;
            xdiv_reg <= asp_pkg::RST_CRYSTAL_DIV;
            osc_reg <= asp_pkg::RST_OSC_AUTO;
        end else if (!sys_reg[asp_pkg::SYS_MODE_RESET_BIT]) begin
            adc_reg <= asp_pkg::RST_ADC_CONTROL_ONE;
            xdiv_reg <= asp_pkg::RST_CRYSTAL_DIV;
            osc_reg <= asp_pkg::RST_OSC_AUTO;
        end else begin
            if (wr_hit(i_addr, asp_pkg::ADDR_ADC_CONTROL_ONE, i_wr)) begin
                adc_reg <= i_wdata;
            end
            if (wr_hit(i_addr, asp_pkg::ADDR_CRYSTAL_DIV, i_wr)) begin
                xdiv_reg <= i_wdata;
            end
            if (wr_hit(i_addr, asp_pkg::ADDR_OSC_AUTO, i_wr)) begin
                osc_reg <= i_wdata;
            end
        end
    end

    // Port rate calculator results, updated only with the receiver powered.
    // Freezing them while the receiver sleeps keeps the last good result readable
    // instead of a half-finished one.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            calc_busy_flag <= 1'b1;
            calc_port_id <= asp_pkg::ASP_PORT_RECEIVER;
            calc_rate_code <= asp_pkg::RATE_OUT_OF_RANGE;
        end else if (rx_on) begin
            if (!i_calc_signal) begin
                calc_busy_flag <= 1'b1;
            end else if (i_calc_done) begin
                calc_busy_flag <= 1'b0;
                calc_port_id <= i_calc_port;
                calc_rate_code <= i_calc_rate;
            end else begin
                calc_busy_flag <= 1'b1;
            end
        end
    end

    // Incoming biphase status; rate held while measuring or unlocked.
    // The limiter reads this rate too, so holding it also steadies that decision.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            incoming_rate_busy <= 1'b1;
            nonaudio_cs_flag <= 1'b0;
            incoming_rate_code <= asp_pkg::RATE_OUT_OF_RANGE;
        end else if (rx_on) begin
            nonaudio_cs_flag <= i_cs_bit1;
            if (!i_rx_locked || !i_in_rate_valid) begin
                incoming_rate_busy <= 1'b1;
            end else begin
                incoming_rate_busy <= 1'b0;
                incoming_rate_code <= i_in_rate;
            end
        end
    end

    // Burst words captured together; flags pulse for each capture.
    // Loading both on one edge means a host never pairs a new info word with an
    // old length word.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            burst_info <= 16'h0000;
            burst_length <= 16'h0000;
            o_burst_update_flag0 <= 1'b0;
            o_burst_update_flag1 <= 1'b0;
        end else begin
            o_burst_update_flag0 <= i_burst_valid && rx_on;
            o_burst_update_flag1 <= i_burst_valid && rx_on;
            if (i_burst_valid && rx_on) begin
                burst_info <= i_burst_info;
                burst_length <= i_burst_length;
            end
        end
    end

    // External ADC data pin synchroniser.
    // Only the second flop is read; the first may still be settling.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
        end else begin
            ext_sync1 <= i_ext_adc_pin;
            ext_sync2 <= ext_sync1;
        end
    end

    // Result image: busy flag on top, then the port measured, then its rate.
    // Built field by field so the busy and port positions follow their package constants; the rate sits at bits 3 to 0.
    always_comb begin
        calc_result_word = 8'h00;
        calc_result_word[asp_pkg::RES_BUSY_BIT] = calc_busy_flag;
        calc_result_word[asp_pkg::RES_PORT_LSB +: 3] = calc_port_id;
        calc_result_word[3:0] = calc_rate_code;
    end

    // Incoming image: busy, non-audio flag, two reserved zeros, incoming rate.
    always_comb begin
        incoming_info_word = 8'h00;
        incoming_info_word[asp_pkg::RES_BUSY_BIT] = incoming_rate_busy;
        incoming_info_word[asp_pkg::INFO_NONAUDIO_BIT] = nonaudio_cs_flag;
        incoming_info_word[3:0] = incoming_rate_code;
    end

    // Read mux; reads only select data and never change state.
    always_comb begin
        next_rdata = 8'h00;
        unique case (i_addr)
            asp_pkg::ADDR_RATE_CALC_TARGET: next_rdata = target_reg;
            asp_pkg::ADDR_RATE_CALC_RESULT: next_rdata = calc_result_word;
            asp_pkg::ADDR_INCOMING_INFO: next_rdata = incoming_info_word;
            asp_pkg::ADDR_BURST_INFO_LO: next_rdata = burst_info[7:0];
            asp_pkg::ADDR_BURST_INFO_HI: next_rdata = burst_info[15:8];
            asp_pkg::ADDR_BURST_LEN_LO: next_rdata = burst_length[7:0];
            asp_pkg::ADDR_BURST_LEN_HI: next_rdata = burst_length[15:8];
            asp_pkg::ADDR_SYSTEM_RESET_POWER: next_rdata = sys_reg;
            asp_pkg::ADDR_ADC_CONTROL_ONE: next_rdata = adc_reg;
            asp_pkg::ADDR_CRYSTAL_DIV: next_rdata = xdiv_reg;
            asp_pkg::ADDR_OSC_AUTO: next_rdata = osc_reg;
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data register, valid the cycle after the read strobe.
    // Zero outside the read slot keeps stray reads visible on the bus.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Control outputs, all registered.
    // Each follows its register one cycle late; that cycle buys a flop on every pin.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_calc_target_sel <= asp_pkg::ASP_PORT_RECEIVER;
            o_calc_enable <= 1'b0;
            o_mode_regs_reset <= 1'b0;
            o_adc_soft_reset <= 1'b0;
            o_adc_powerdown <= 1'b0;
            o_receiver_powerdown <= 1'b0;
            o_transmitter_powerdown <= 1'b0;
            o_oscillator_enable <= 1'b0;
            o_adc_clkout_enable <= 1'b1;
            o_main_data <= 1'b0;
            o_adc_clock_source <= asp_pkg::ASP_CLK_CRYSTAL;
            o_crystal_sysclk_div <= asp_pkg::RST_CRYSTAL_DIV[asp_pkg::CRYSTAL_SYSCLK_DIV_LSB +: 2];
        end else begin
            o_calc_target_sel <= target_reg[2:0];
            o_calc_enable <= rx_on;
            o_mode_regs_reset <= !sys_reg[asp_pkg::SYS_MODE_RESET_BIT];
            o_adc_soft_reset <= !sys_reg[asp_pkg::SYS_ADC_RESET_BIT];
            o_adc_powerdown <= adc_pd_eff;
            o_receiver_powerdown <= sys_reg[asp_pkg::SYS_RX_PD_BIT];
            o_transmitter_powerdown <= sys_reg[asp_pkg::SYS_TX_PD_BIT];
            // The power-down bit beats the auto request whichever way it points.
            // oscillator override
            o_oscillator_enable <= !sys_reg[asp_pkg::SYS_OSC_PD_BIT]
                && (!osc_reg[asp_pkg::OSC_AUTO_BIT] || i_osc_auto_req);
            // The gate only bites while the ADC is really down, forced or not.
            // clock output gate
            o_adc_clkout_enable <= !(adc_reg[asp_pkg::ADC_CLKOUT_GATE_BIT] && adc_pd_eff);
            o_main_data <= adc_reg[asp_pkg::ADC_DATA_SRC_BIT] ? ext_sync2 : i_adc_data;
            o_adc_clock_source <= clk_src_field;
            o_crystal_sysclk_div <= xdiv_field;
        end
    end
endmodule

// ### asp_regs_props.sv
// Concurrent checks on the ports of the status and power register bank.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module asp_regs_props (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_burst_valid,
    input wire logic o_burst_update_flag0,
    input wire logic [2:0] o_calc_target_sel,
    input wire logic o_mode_regs_reset,
    input wire logic o_adc_soft_reset,
    input wire logic o_receiver_powerdown,
    input wire logic o_oscillator_enable,
    input wire logic [2:0] o_adc_clock_source
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Decode of host writes to the system and control registers.
    logic sys_wr;
    logic ctl_wr;
    assign sys_wr = i_wr && i_addr == 8'h40;
    assign ctl_wr = i_wr && i_addr == 8'h42;
    a_rdata_idle: assert property ($past(!i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_target_follows: assert property (i_wr && i_addr == 8'h37 |-> ##2
        o_calc_target_sel == $past(i_wdata[2:0], 2))
        else $error("target select did not follow write");
    a_mode_reset_pulse: assert property (sys_wr && !i_wdata[7] |->
        ##[1:3] o_mode_regs_reset)
        else $error("mode reset pulse missing");
    a_mode_pulse_short: assert property ($rose(o_mode_regs_reset) |=> !o_mode_regs_reset)
        else $error("mode reset pulse too long");
    a_adc_reset_pulse: assert property (sys_wr && !i_wdata[6] |-> ##[1:3] o_adc_soft_reset)
        else $error("adc reset pulse missing");
    a_rx_pd_follows: assert property (sys_wr && i_wdata[7] |-> ##2
        o_receiver_powerdown == $past(i_wdata[4], 2))
        else $error("receiver power-down mismatch");
    a_osc_pd_wins: assert property (sys_wr && i_wdata[7] && i_wdata[0] |->
        ##2 !o_oscillator_enable)
        else $error("oscillator still enabled");
    a_clk_src_follows: assert property (ctl_wr |-> ##2
        o_adc_clock_source == $past(i_wdata[2:0], 2))
        else $error("clock source mismatch");
    a_burst_flag: assert property (i_burst_valid |-> ##[1:2] o_burst_update_flag0)
        else $error("burst update flag missing");
    // Main scenarios reached.
    c_mode_reset: cover property (o_mode_regs_reset);
    c_burst: cover property (i_burst_valid);
    c_rx_off: cover property (o_receiver_powerdown);
endmodule
bind asp_regs asp_regs_props i_asp_regs_props (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_burst_valid, .o_burst_update_flag0, .o_calc_target_sel, .o_mode_regs_reset,
    .o_adc_soft_reset, .o_receiver_powerdown, .o_oscillator_enable, .o_adc_clock_source);

// ### asp_regs_tb.sv
// Self-checking bench for the status and power register bank.
// Assumes the bank answers reads one cycle later and never stalls.
`timescale 1ns/1ps
module asp_regs_tb;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, cdone = 0, csig = 0, lock = 0, ival = 0, cs1 = 0;
    logic bval = 0, adat = 0, epin = 0, oreq = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [2:0] cport = 3'h0, tsel, csrc;
    logic [3:0] crate = 4'h0, irate = 4'h0;
    logic [15:0] binfo = 16'h0000, blen = 16'h0000;
    logic [1:0] cdiv;
    logic fl0, fl1, mode_regs_reset, arst, apd, rpd, tpd, oen, cken, mdat, cen;
    int fails = 0, n_checks = 0;
    // Clock at 100 MHz.
    always #5 clk = ~clk;
    asp_regs i_asp_regs (.i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdat), .i_calc_done(cdone), .i_calc_port(cport), .i_calc_rate(crate),
        .i_calc_signal(csig), .i_rx_locked(lock), .i_in_rate_valid(ival), .i_in_rate(irate),
        .i_cs_bit1(cs1), .i_burst_valid(bval), .i_burst_info(binfo), .i_burst_length(blen),
        .i_adc_data(adat), .i_ext_adc_pin(epin), .i_osc_auto_req(oreq), .o_calc_target_sel(tsel),
        .o_calc_enable(cen), .o_burst_update_flag0(fl0), .o_burst_update_flag1(fl1),
        .o_mode_regs_reset(mode_regs_reset), .o_adc_soft_reset(arst), .o_adc_powerdown(apd),
        .o_receiver_powerdown(rpd), .o_transmitter_powerdown(tpd), .o_oscillator_enable(oen),
        .o_adc_clkout_enable(cken), .o_main_data(mdat), .o_adc_clock_source(csrc),
        .o_crystal_sysclk_div(cdiv));
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wd <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read with a mask over fields whose content is not defined.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk((rdat & m) === (e & m), $sformatf("read %h got %h want %h", a, rdat, e));
    endtask
    // Waits a few cycles for a one-cycle pulse.
    task automatic see(ref logic s, input string msg);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 5) begin
            @(posedge clk); #1; k++;
        end
        chk(s === 1'b1, msg);
    endtask
    task automatic t_reset_values;
        rdc(8'h37, asp_pkg::RST_RATE_CALC_TARGET, 8'hFF);
        rdc(8'h40, asp_pkg::RST_SYSTEM_RESET_POWER, 8'hFF);
        rdc(8'h42, asp_pkg::RST_ADC_CONTROL_ONE, 8'hFF);
        rdc(8'h31, asp_pkg::RST_CRYSTAL_DIV, 8'hFF);
        chk(cdiv === 2'b01 && cken === 1'b1 && apd === 1'b0, "reset outputs");
        chk(oen === 1'b1 && cen === 1'b1, "oscillator and calculator on");
        rdc(8'h50, 8'h00, 8'hFF);
        $display("test reset values done");
    endtask
    task automatic t_target;
        for (int i = 0; i < 8; i++) begin
            wrr(8'h37, 8'(i));
            idle(2);
            chk(tsel === 3'(i), "target select");
            rdc(8'h37, 8'(i), 8'hFF);
        end
        $display("test target done");
    endtask
    task automatic t_calc;
        cdone <= 1; csig <= 1; cport <= 3'h5; crate <= 4'hC;
        idle(4);
        rdc(8'h38, 8'h5C, 8'hFF);
        rdc(8'h38, 8'h5C, 8'hFF);
        csig <= 0; crate <= 4'h3;
        idle(4);
        rdc(8'h38, 8'h8C, 8'h8F);
        csig <= 1;
        $display("test calculator done");
    endtask
    task automatic t_incoming;
        lock <= 1; ival <= 1; irate <= 4'h9; cs1 <= 1;
        idle(4);
        rdc(8'h39, 8'h49, 8'hCF);
        ival <= 0; irate <= 4'h2;
        idle(4);
        rdc(8'h39, 8'hC9, 8'hCF);
        wrr(8'h40, 8'hD0);
        ival <= 1; irate <= 4'h5; cs1 <= 0;
        idle(4);
        rdc(8'h39, 8'hC9, 8'hCF);
        chk(cen === 1'b0 && rpd === 1'b1, "receiver powered down");
        wrr(8'h40, 8'hC0);
        $display("test incoming done");
    endtask
    task automatic t_burst;
        binfo <= 16'hA5C3; blen <= 16'h1234;
        @(posedge clk);
        bval <= 1;
        @(posedge clk);
        bval <= 0;
        #1;
        see(fl0, "burst update flag");
        chk(fl1 === 1'b1, "burst update flag one");
        rdc(8'h3A, 8'hC3, 8'hFF);
        rdc(8'h3B, 8'hA5, 8'hFF);
        rdc(8'h3C, 8'h34, 8'hFF);
        rdc(8'h3D, 8'h12, 8'hFF);
        $display("test burst done");
    endtask
    task automatic t_system;
        oreq <= 1;
        wrr(8'h30, 8'h01);
        wrr(8'h40, 8'hFF);
        idle(2);
        chk(apd === 1 && rpd === 1 && tpd === 1 && oen === 0, "power-down bits");
        rdc(8'h40, 8'hFF, 8'hFF);
        wrr(8'h40, 8'hBF);
        see(arst, "adc reset pulse");
        rdc(8'h40, 8'hFF, 8'hFF);
        wrr(8'h37, 8'h03);
        wrr(8'h42, 8'h13);
        wrr(8'h40, 8'h7F);
        see(mode_regs_reset, "mode reset pulse");
        idle(2);
        rdc(8'h40, 8'hC0, 8'hFF);
        rdc(8'h37, 8'h00, 8'hFF);
        rdc(8'h42, 8'h02, 8'hFF);
        $display("test system done");
    endtask
    task automatic t_adc;
        for (int c = 0; c < 6; c++) begin
            wrr(8'h42, 8'(c));
            idle(2);
            chk(csrc === 3'(c), "clock source code");
        end
        wrr(8'h42, 8'h12); epin <= 1; idle(5);
        chk(mdat === 1'b1, "external data high");
        epin <= 0; idle(5);
        chk(mdat === 1'b0, "external data low");
        wrr(8'h42, 8'h02); adat <= 1; idle(3);
        chk(mdat === 1'b1, "internal data");
        wrr(8'h40, 8'hE0); wrr(8'h42, 8'h22); idle(2);
        chk(cken === 1'b0, "clock outputs gated");
        wrr(8'h42, 8'h02); idle(2);
        chk(cken === 1'b1, "clock outputs kept");
        wrr(8'h40, 8'hC0); lock <= 1; ival <= 1; irate <= 4'h9;
        wrr(8'h42, 8'h09); idle(4);
        chk(apd === 1'b1, "limiter forces power-down");
        irate <= 4'hD; idle(4);
        chk(apd === 1'b0, "limiter outside window");
        wrr(8'h31, 8'h3A); idle(2);
        chk(cdiv === 2'b11, "crystal divider");
        $display("test adc done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
    // Main sequence.
    initial begin
        idle(10);
        rstn <= 1;
        t_reset_values();
        t_target();
        t_calc();
        t_incoming();
        t_burst();
        t_system();
        t_adc();
        close_out();
    end
endmodule
